/* gcd_consts.svh */
`ifndef GCD_CONSTS_SVH
`define GCD_CONSTS_SVH

// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define GCD_ADDR_DRIVE_CFG   8'h00
`define GCD_ADDR_CFG_SECOND  8'h04
`define GCD_ADDR_OUT_VALUE   8'h08
`define GCD_ADDR_ROUTE_SEL   8'h0C
`define GCD_ADDR_PIN_STATE   8'h10

// -----------------------------------------------------------------
// Field positions and widths
// -----------------------------------------------------------------
`define GCD_MODE_W           3
`define GCD_ROUTE_W          4
`define GCD_THRESH_BIT       24
`define GCD_SLOW_BIT         25
`define GCD_INP_OFF_BIT      0

// -----------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------
`define GCD_DRIVE_RST        32'h0000_0000
`define GCD_ROUTE_RST        32'h0000_0000
`define GCD_ROUTE_FW         4'h0
`define GCD_RESP_OKAY        2'h0
`define GCD_RESP_SLVERR      2'h2

`endif

/* gcd_pkg.sv */
package gcd_pkg;

    // Per-pin drive modes, in encoding order 0..7
    typedef enum logic [2:0] {
        GCD_HIZ_ANALOG,
        GCD_HIZ_DIGITAL,
        GCD_PULL_UP,
        GCD_PULL_DOWN,
        GCD_OD_LOW,
        GCD_OD_HIGH,
        GCD_STRONG,
        GCD_PULL_BOTH
    } gcd_mode_t;

endpackage : gcd_pkg

/* gcd_port.sv */
// Summary of operation
// RULE1 - Each pin has a 3-bit drive-mode field at bits 3y+2 to 3y of the drive register.
// RULE2 - Modes 0 and 1 never drive the pin, and mode 1 keeps the input buffer on.
// RULE3 - Mode 2 is weak high/strong low, mode 3 strong high/weak low, mode 7 weak both.
// RULE4 - Mode 4 floats a one and drives a strong zero, mode 5 the reverse, mode 6 strong both.
// RULE5 - After reset every pin is analog high-Z with driver and input buffer off.
// RULE6 - A pin in analog high-Z reads zero in the pin-state register.
// RULE7 - The input-off bit of the second config register disables the port's input buffers.
// RULE8 - Bit 24 of the drive register selects CMOS (0) or LVTTL (1) thresholds for the port.
// RULE9 - Bit 25 of the drive register resets to fast slew and selects slow slew when set.
// RULE10 - Each pin's input buffer output is routed to the peripheral chosen by its route field.
// RULE11 - Each driver's data and enable come from the peripheral or the output-value register.
// RULE12 - Software writes one to a data bit for pull-up, zero for pull-down.
// RULE13 - Each pin has a 4-bit route field, value 0 selecting firmware data.
// RULE14 - Configuration writes reach the pin controls on the cycle after the write.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "gcd_consts.svh"

module gcd_port
    import gcd_pkg::*;
#(
    parameter int NPINS = 8
) (
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               clk_en,
    // AXI4-Lite write channels
    input  wire logic [7:0]         s_awaddr,
    input  wire logic               s_awvalid,
    output logic                    s_awready,
    input  wire logic [31:0]        s_wdata,
    input  wire logic [3:0]         s_wstrb,
    input  wire logic               s_wvalid,
    output logic                    s_wready,
    output logic [1:0]              s_bresp,
    output logic                    s_bvalid,
    input  wire logic               s_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]         s_araddr,
    input  wire logic               s_arvalid,
    output logic                    s_arready,
    output logic [31:0]             s_rdata,
    output logic [1:0]              s_rresp,
    output logic                    s_rvalid,
    input  wire logic               s_rready,
    // Peripheral side
    input  wire logic [NPINS-1:0]   periph_out,
    input  wire logic [NPINS-1:0]   periph_oe,
    output logic [NPINS-1:0]        routed_in,
    output logic [4*NPINS-1:0]      route_sel,
    // Pad side
    input  wire logic [NPINS-1:0]   pad_in,
    output logic [NPINS-1:0]        pad_out,
    output logic [NPINS-1:0]        pad_oe,
    output logic [NPINS-1:0]        pad_strong,
    output logic [NPINS-1:0]        pad_ibuf_en,
    output logic                    pad_lvttl,
    output logic                    pad_slow
);

    // -----------------------------------------------------------------
    // Helper functions
    // -----------------------------------------------------------------
    // Drive strength for a given mode and data value: 2=strong,1=weak,0=off
    function automatic logic [1:0] drive_of(input gcd_mode_t m, input logic d);
        logic [1:0] r;
        r = 2'h0;
        case (m)
            GCD_PULL_UP:   r = d ? 2'h1 : 2'h2;
            GCD_PULL_DOWN: r = d ? 2'h2 : 2'h1;
            GCD_OD_LOW:    r = d ? 2'h0 : 2'h2;
            GCD_OD_HIGH:   r = d ? 2'h2 : 2'h0;
            GCD_STRONG:    r = 2'h2;
            GCD_PULL_BOTH: r = 2'h1;
            default:       r = 2'h0;
        endcase
        return r;
    endfunction : drive_of

    // Merge a write word into a register under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [31:0]        drive_cfg_q;
    logic               input_buffer_off_q;
    logic [NPINS-1:0]   out_value_q;
    logic [31:0]        route_q;
    logic [NPINS-1:0]   pin_sync1_q;
    logic [NPINS-1:0]   pin_sync2_q;
    logic [7:0]         awaddr_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;
    logic               aw_held_q;
    logic               w_held_q;
    logic               wr_go;
    logic [NPINS-1:0]   pin_state;

    assign wr_go = aw_held_q && w_held_q && !s_bvalid;

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 8'h00;
            s_awready <= 1'b0;
        end else if (clk_en) begin
            s_awready <= !aw_held_q && !s_awready;
            if (s_awvalid && s_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_awaddr;
                s_awready <= 1'b0;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            s_wready <= 1'b0;
        end else if (clk_en) begin
            s_wready <= !w_held_q && !s_wready;
            if (s_wvalid && s_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_wdata;
                wstrb_q  <= s_wstrb;
                s_wready <= 1'b0;
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Register update and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_cfg_q        <= `GCD_DRIVE_RST; // RULE5 RULE9
            input_buffer_off_q <= 1'b0;
            out_value_q        <= '0;
            route_q            <= `GCD_ROUTE_RST;
            s_bvalid           <= 1'b0;
            s_bresp            <= `GCD_RESP_OKAY;
        end else if (clk_en) begin
            if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
            if (wr_go) begin
                s_bvalid <= 1'b1;
                s_bresp  <= `GCD_RESP_OKAY;
                if (awaddr_q == `GCD_ADDR_DRIVE_CFG) begin
                    drive_cfg_q <= merge(drive_cfg_q, wdata_q, wstrb_q); // RULE1 RULE8
                end else if (awaddr_q == `GCD_ADDR_CFG_SECOND) begin
                    if (wstrb_q[0]) begin
                        input_buffer_off_q <= wdata_q[`GCD_INP_OFF_BIT]; // RULE7
                    end
                end else if (awaddr_q == `GCD_ADDR_OUT_VALUE) begin
                    if (wstrb_q[0]) begin
                        out_value_q <= wdata_q[NPINS-1:0];
                    end
                end else if (awaddr_q == `GCD_ADDR_ROUTE_SEL) begin
                    route_q <= merge(route_q, wdata_q, wstrb_q); // RULE13
                end else if (awaddr_q == `GCD_ADDR_PIN_STATE) begin
                    s_bresp <= `GCD_RESP_OKAY;
                end else begin
                    s_bresp <= `GCD_RESP_SLVERR;
                end
            end
        end
    end

    // Pad input synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync1_q <= '0;
            pin_sync2_q <= '0;
        end else if (clk_en) begin
            pin_sync1_q <= pad_in;
            pin_sync2_q <= pin_sync1_q;
        end
    end

    // Pin state, forced to zero while the input buffer is off
    always_comb begin
        for (int y = 0; y < NPINS; y++) begin
            pin_state[y] = pad_ibuf_en[y] && pin_sync2_q[y]; // RULE6
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= `GCD_RESP_OKAY;
        end else if (clk_en) begin
            s_arready <= !s_rvalid && !s_arready;
            if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
            if (s_arvalid && s_arready) begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rresp   <= `GCD_RESP_OKAY;
                s_rdata   <= 32'h0000_0000;
                if (s_araddr == `GCD_ADDR_DRIVE_CFG) begin
                    s_rdata <= drive_cfg_q;
                end else if (s_araddr == `GCD_ADDR_CFG_SECOND) begin
                    s_rdata <= {31'h0000_0000, input_buffer_off_q};
                end else if (s_araddr == `GCD_ADDR_OUT_VALUE) begin
                    s_rdata <= 32'(out_value_q);
                end else if (s_araddr == `GCD_ADDR_ROUTE_SEL) begin
                    s_rdata <= route_q;
                end else if (s_araddr == `GCD_ADDR_PIN_STATE) begin
                    s_rdata <= 32'(pin_state); // RULE6
                end else begin
                    s_rresp <= `GCD_RESP_SLVERR;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // Pin control outputs, registered one cycle after the config write
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_out     <= '0;
            pad_oe      <= '0; // RULE5
            pad_strong  <= '0;
            pad_ibuf_en <= '0; // RULE5
            pad_lvttl   <= 1'b0;
            pad_slow    <= 1'b0;
            routed_in   <= '0;
            route_sel   <= '0;
        end else if (clk_en) begin
            pad_lvttl <= drive_cfg_q[`GCD_THRESH_BIT]; // RULE8 RULE14
            pad_slow  <= drive_cfg_q[`GCD_SLOW_BIT]; // RULE9 RULE14
            route_sel <= route_q[4*NPINS-1:0]; // RULE13
            for (int y = 0; y < NPINS; y++) begin
                gcd_mode_t  m;
                logic       fw;
                logic       d;
                logic [1:0] s;
                m  = gcd_mode_t'(drive_cfg_q[`GCD_MODE_W*y +: `GCD_MODE_W]); // RULE1
                fw = route_q[`GCD_ROUTE_W*y +: `GCD_ROUTE_W] == `GCD_ROUTE_FW;
                d  = fw ? out_value_q[y] : periph_out[y]; // RULE11 RULE12
                s  = drive_of(m, d); // RULE2 RULE3 RULE4
                pad_out[y]     <= d;
                pad_oe[y]      <= (s != 2'h0) && (fw || periph_oe[y]); // RULE11
                pad_strong[y]  <= s == 2'h2;
                pad_ibuf_en[y] <= (m != GCD_HIZ_ANALOG) && !input_buffer_off_q; // RULE2 RULE7
                routed_in[y]   <= pin_sync2_q[y] && pad_ibuf_en[y]; // RULE10
            end
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    mode_hiz_off_a: assert property (clk_en && drive_cfg_q[2:0] <= 3'h1 |=> !pad_oe[0]) // RULE2
        else $error("pin 0 driven in high-Z mode");
    mode_strong_a: assert property (clk_en && drive_cfg_q[2:0] == 3'h6 && route_q[3:0] == 4'h0
        |=> pad_oe[0] && pad_strong[0]) // RULE4
        else $error("strong mode not strong");
    od_low_a: assert property (clk_en && drive_cfg_q[2:0] == 3'h4 && route_q[3:0] == 4'h0
        && out_value_q[0] |=> !pad_oe[0]) // RULE4
        else $error("open drain low drove a one");
    pull_up_a: assert property (clk_en && drive_cfg_q[2:0] == 3'h2 && route_q[3:0] == 4'h0
        && out_value_q[0] |=> pad_oe[0] && !pad_strong[0]) // RULE3
        else $error("pull-up one not weak");
    analog_ibuf_a: assert property (clk_en && drive_cfg_q[2:0] == 3'h0 |=> !pad_ibuf_en[0]) // RULE5
        else $error("input buffer on in analog mode");
    ibuf_off_a: assert property (clk_en && input_buffer_off_q |=> pad_ibuf_en == '0) // RULE7
        else $error("input buffer not disabled");
    thresh_follow_a: assert property (clk_en |=> pad_lvttl == $past(drive_cfg_q[24])) // RULE8
        else $error("threshold select lagging");
    slew_follow_a: assert property (clk_en |=> pad_slow == $past(drive_cfg_q[25])) // RULE9
        else $error("slew select lagging");
    analog_read_a: assert property (!pad_ibuf_en[0] |-> !pin_state[0]) // RULE6
        else $error("analog pin reads one");
    periph_oe_a: assert property (clk_en && route_q[3:0] != 4'h0 && !periph_oe[0]
        |=> !pad_oe[0]) // RULE11
        else $error("driver on without peripheral enable");

    wr_cov: cover property (s_bvalid && s_bready);
    rd_cov: cover property (s_rvalid && s_rready);
    strong_cov: cover property (pad_strong[0] && pad_oe[0]);

endmodule : gcd_port

/* gcd_board.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Board circuitry on the port pins
// ------------------------------------------------------------
module gcd_board (
    // Pin drivers from the port
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    // Board pull level seen on a released pin
    input  wire logic [7:0] ext_level,
    // Levels seen at the pads
    output logic [7:0]      pad_in
);
    // Driven pins follow the port, released pins settle to the board pull
    always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : gcd_board

/* gcd_port_tb_top.sv */
`timescale 1ns/1ps
`include "gcd_consts.svh"

module gcd_port_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic        clk_en;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, pad_lvttl, pad_slow;
    logic [7:0]  s_awaddr, s_araddr, periph_out, periph_oe, ext_level, pad_in;
    logic [7:0]  routed_in, pad_out, pad_oe, pad_strong, pad_ibuf_en;
    logic [31:0] s_wdata, s_rdata, route_sel;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp;
    int          n_fail, comparisons;

    gcd_port #(.NPINS(8)) i_gcd_port (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .periph_out(periph_out), .periph_oe(periph_oe), .routed_in(routed_in),
        .route_sel(route_sel), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_strong(pad_strong), .pad_ibuf_en(pad_ibuf_en), .pad_lvttl(pad_lvttl),
        .pad_slow(pad_slow)
    );

    gcd_board i_gcd_board (
        .pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in)
    );

    // 25 MHz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic hang(input int n);
        if (n >= 100) begin
            n_fail++;
            $display("mismatch at %0t: bus answer never came", $time);
            conclude();
        end
    endtask : hang

    // Write one word; address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) break;
        end
        s_bready <= 1'b0;
        hang(n);
        chk(32'(s_bresp), 32'(er), "write response");
    endtask : wr

    // Read one word
    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) break;
        end
        v = s_rdata;
        s_rready <= 1'b0;
        hang(n);
        chk(32'(s_rresp), 32'(er), "read response");
    endtask : rd

    // Expected {driver on, strong} for a mode and data bit
    function automatic logic [1:0] drv(input logic [2:0] m, input logic d);
        case (m)
            3'h2: drv = {1'b1, !d};
            3'h3: drv = {1'b1, d};
            3'h4: drv = {!d, !d};
            3'h5: drv = {d, d};
            3'h6: drv = 2'h3;
            3'h7: drv = 2'h2;
            default: drv = 2'h0;
        endcase
    endfunction : drv

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin : main
        logic [31:0] cfg, v;
        logic [7:0]  eoe, est, eib, d;
        logic [1:0]  x;
        int          k, j, y;
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
        {s_awaddr, s_araddr, periph_out, periph_oe} = 32'h0000_0000;
        s_wdata = 32'h0000_0000;
        s_wstrb = 4'hF;
        clk_en = 1'b1;
        ext_level = 8'hFF;
        repeat (20) @(posedge aclk);
        chk({pad_oe, pad_strong, pad_ibuf_en, pad_lvttl, pad_slow}, 32'h0, "reset pins");
        aresetn <= 1'b1;
        for (j = 0; j <= 16; j += 4) begin
            rd(8'(j), v, `GCD_RESP_OKAY);
            chk(v, 32'h0, "reset register");
        end
        wr(`GCD_ADDR_OUT_VALUE, 32'h0000_00FF, `GCD_RESP_OKAY);
        repeat (4) @(posedge aclk);
        rd(`GCD_ADDR_PIN_STATE, v, `GCD_RESP_OKAY);
        chk(v, 32'h0, "analog pin state");
        wr(8'h14, 32'hFFFF_FFFF, `GCD_RESP_SLVERR);
        rd(8'h14, v, `GCD_RESP_SLVERR);
        wr(`GCD_ADDR_PIN_STATE, 32'h0000_00FF, `GCD_RESP_OKAY);
        // Every mode on every pin, both data values, all threshold and slew pairs
        ext_level <= 8'h0F;
        for (k = 0; k < 16; k++) begin
            d = k[0] ? 8'h55 : 8'hAA;
            x = 2'(k >> 2);
            cfg = {6'h00, x, 24'h00_0000};
            for (y = 0; y < 8; y++) begin
                cfg[3*y +: 3] = 3'(y + (k >> 1));
                {eoe[y], est[y]} = drv(cfg[3*y +: 3], d[y]);
                eib[y] = (cfg[3*y +: 3] != 3'h0);
            end
            wr(`GCD_ADDR_OUT_VALUE, {24'h00_0000, d}, `GCD_RESP_OKAY);
            wr(`GCD_ADDR_DRIVE_CFG, cfg, `GCD_RESP_OKAY);
            repeat (4) @(posedge aclk);
            chk(pad_oe, eoe, "driver on");
            chk(pad_strong & eoe, est, "strength");
            chk(pad_out & eoe, d & eoe, "pad data");
            chk(pad_ibuf_en, eib, "input buffer");
            chk({pad_slow, pad_lvttl}, x, "threshold and slew");
            rd(`GCD_ADDR_PIN_STATE, v, `GCD_RESP_OKAY);
            chk(v, ((eoe & d) | (~eoe & 8'h0F)) & eib, "pin state");
        end
        wr(`GCD_ADDR_DRIVE_CFG, 32'h0000_0000, `GCD_RESP_OKAY);
        chk(pad_slow, 1'b1, "slew before update");
        @(posedge aclk);
        chk(pad_slow, 1'b0, "slew after update");
        // Upper pins routed to a peripheral, lower pins on firmware data
        ext_level <= 8'h00;
        periph_out <= 8'hA0;
        periph_oe <= 8'h60;
        wr(`GCD_ADDR_OUT_VALUE, 32'h0000_000F, `GCD_RESP_OKAY);
        wr(`GCD_ADDR_ROUTE_SEL, 32'h8888_0000, `GCD_RESP_OKAY);
        wr(`GCD_ADDR_DRIVE_CFG, 32'h00DB_6DB6, `GCD_RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(route_sel, 32'h8888_0000, "route copy");
        chk(pad_oe, 8'h6F, "routed enable");
        chk(pad_out & 8'h6F, 8'h2F, "routed data");
        chk(routed_in, 8'h2F, "routed input");
        // Clock enable low freezes the pin controls
        clk_en <= 1'b0;
        periph_out <= 8'h50;
        repeat (4) @(posedge aclk);
        chk(pad_out & 8'hF0, 8'hA0, "frozen pad data");
        clk_en <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(pad_out & 8'hF0, 8'h50, "resumed pad data");
        wr(`GCD_ADDR_CFG_SECOND, 32'h0000_0001, `GCD_RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(routed_in, 8'h00, "input off routed");
        chk(pad_ibuf_en, 8'h00, "input off buffer");
        rd(`GCD_ADDR_PIN_STATE, v, `GCD_RESP_OKAY);
        chk(v, 32'h0, "input off state");
        rd(`GCD_ADDR_CFG_SECOND, v, `GCD_RESP_OKAY);
        chk(v, 32'h1, "second config readback");
        conclude();
    end
endmodule : gcd_port_tb_top
